// file: sdc_pkg.sv
package sdc_pkg;

  // ---------------------------------------------------------------
  // special function register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_AUX_CONFIG      = 8'hD3;
  localparam logic [7:0] ADDR_DECIMATION      = 8'hD4;
  localparam logic [7:0] ADDR_PRI_RESULT_MID  = 8'hDA;
  localparam logic [7:0] ADDR_PRI_RESULT_HIGH = 8'hDB;
  localparam logic [7:0] ADDR_AUX_RESULT_LOW  = 8'hDC;
  localparam logic [7:0] ADDR_AUX_RESULT_HIGH = 8'hDD;
  localparam logic [7:0] ADDR_PRI_OFFSET_MID  = 8'hE2;
  localparam logic [7:0] ADDR_PRI_OFFSET_HIGH = 8'hE3;
  localparam logic [7:0] ADDR_AUX_OFFSET_LOW  = 8'hE4;
  localparam logic [7:0] ADDR_AUX_OFFSET_HIGH = 8'hE5;
  localparam logic [7:0] ADDR_PRI_GAIN_MID    = 8'hEA;
  localparam logic [7:0] ADDR_PRI_GAIN_HIGH   = 8'hEB;
  localparam logic [7:0] ADDR_AUX_GAIN_LOW    = 8'hEC;
  localparam logic [7:0] ADDR_AUX_GAIN_HIGH   = 8'hED;

  // ---------------------------------------------------------------
  // auxiliary config field positions and channel codes
  // ---------------------------------------------------------------
  localparam int          AUX_EXT_REF_BIT  = 6;
  localparam int          AUX_CH_HI_BIT    = 5;
  localparam int          AUX_CH_LO_BIT    = 4;
  localparam int          AUX_UNIPOLAR_BIT = 3;
  localparam logic [7:0]  AUX_CONFIG_MASK  = 8'h78;
  localparam logic [1:0]  AUX_CH_IN_THREE  = 2'h0;
  localparam logic [1:0]  AUX_CH_IN_FOUR   = 2'h1;
  localparam logic [1:0]  AUX_CH_TEMP      = 2'h2;
  localparam logic [1:0]  AUX_CH_IN_FIVE   = 2'h3;

  // ---------------------------------------------------------------
  // reset values and coding constants
  // ---------------------------------------------------------------
  localparam logic [7:0]  AUX_CONFIG_RESET = 8'h00;
  localparam logic [7:0]  RESULT_RESET     = 8'h00;
  localparam logic [15:0] OFFSET_RESET     = 16'h8000;
  localparam logic [15:0] BIPOLAR_ZERO     = 16'h8000;
  localparam logic [15:0] UNIPOLAR_ZERO    = 16'h0000;
  localparam logic [7:0]  TEMP_ZERO_HIGH   = 8'h80;
  localparam logic [7:0]  DECIMATION_RESET = 8'h45;
  localparam logic [7:0]  DECIMATION_CAL   = 8'hFF;
  localparam logic [7:0]  READ_UNMAPPED    = 8'h00;

  // ---------------------------------------------------------------
  // converter mode field codes
  // ---------------------------------------------------------------
  localparam logic [2:0]  MODE_POWER_DOWN  = 3'h0;
  localparam logic [2:0]  MODE_INT_ZERO    = 3'h4;
  localparam logic [2:0]  MODE_INT_FULL    = 3'h5;
  localparam logic [2:0]  MODE_SYS_ZERO    = 3'h6;
  localparam logic [2:0]  MODE_SYS_FULL    = 3'h7;

  // ---------------------------------------------------------------
  // timing: modulator clock and conversion period
  // ---------------------------------------------------------------
  localparam int          CLOCK_HZ         = 200_000_000;
  localparam int          MOD_CLOCK_HZ     = 32_768;
  localparam int          MOD_DIV_CYCLES   = CLOCK_HZ / MOD_CLOCK_HZ;
  localparam int          CHOP_FACTOR      = 3;
  localparam int          DECIM_STEP       = 8;
  localparam int          SETTLE_PERIODS   = 2;
  localparam int          PERIOD_W         = 13;

  // controller states
  typedef enum logic [1:0] {
    SDC_IDLE = 2'b00,
    SDC_CONV = 2'b01,
    SDC_CAL  = 2'b10
  } sdc_state_e;

endpackage : sdc_pkg

// file: sdc_rate_gen.sv
`timescale 1ns/1ps
// conversion period timer for one converter
module sdc_rate_gen
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // control
  input  wire logic       mod_tick,
  input  wire logic       run,
  input  wire logic [7:0] decim,
  // events
  output logic            period_tick,
  output logic            data_ready
);

  logic [sdc_pkg::PERIOD_W-1:0] count_q;
  logic [sdc_pkg::PERIOD_W-1:0] period_len;
  logic [1:0]                   settled_q;

  // one conversion period is 3 x 8 x decimation modulator ticks
  assign period_len = sdc_pkg::PERIOD_W'(sdc_pkg::CHOP_FACTOR * sdc_pkg::DECIM_STEP) * {5'h00, decim};
  assign period_tick = run && mod_tick && (count_q == period_len - 13'h0001);
  // chopped inputs: valid only from the second period on
  assign data_ready = period_tick && (settled_q >= 2'(sdc_pkg::SETTLE_PERIODS - 1));

  // period counter
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      count_q <= '0;
    else if (!run)
      count_q <= '0;
    else if (mod_tick)
      count_q <= period_tick ? '0 : count_q + 13'h0001;
  end

  // settling counter, restarts with every run
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      settled_q <= '0;
    else if (!run)
      settled_q <= '0;
    else if (period_tick && settled_q != 2'h3)
      settled_q <= settled_q + 2'h1;
  end

endmodule // sdc_rate_gen

// file: sdc_conv_ctrl.sv
`timescale 1ns/1ps
module sdc_conv_ctrl
#(
  parameter int           MOD_DIV        = sdc_pkg::MOD_DIV_CYCLES,
  parameter logic [15:0]  PRI_GAIN_RESET = 16'h5000,  // arbitrary factory value
  parameter logic [15:0]  AUX_GAIN_RESET = 16'h5000   // arbitrary factory value
)
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // special function register port
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_rd,
  output logic [7:0]       sfr_rdata,
  // converter mode control
  input  wire logic [2:0]  conversion_mode_field,
  input  wire logic        pri_enable,
  input  wire logic        aux_enable,
  output logic             mode_clear,
  // filter samples, signed
  input  wire logic [15:0] pri_sample,
  input  wire logic [15:0] aux_sample,
  input  wire logic [7:0]  temp_degrees,
  input  wire logic [15:0] pri_cal_word,
  input  wire logic [15:0] aux_cal_word,
  // analog routing
  output logic             aux_external_ref_select,
  output logic             aux_channel_sel_hi,
  output logic             aux_channel_sel_lo,
  output logic             aux_temp_route,
  output logic             mod_tick_out,
  // status events
  output logic             pri_done_flag,
  output logic             aux_done_flag,
  output logic             aux_fault_flag
);

  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  sdc_pkg::sdc_state_e state_q;
  logic [7:0]          aux_config_q;
  logic [7:0]          decimation_q;
  logic [15:0]         pri_result_q;
  logic [15:0]         aux_result_q;
  logic [15:0]         pri_offset_q;
  logic [15:0]         aux_offset_q;
  logic [15:0]         pri_gain_q;
  logic [15:0]         aux_gain_q;
  logic [12:0]         div_q;
  logic                mod_tick;
  logic                mode_idle;
  logic                mode_cal;
  logic                mode_full;
  logic                pri_run;
  logic                aux_run;
  logic [7:0]          decim_eff;
  logic                pri_ready;
  logic                aux_ready;
  logic                temp_sel;
  logic                pri_cal_done;
  logic                aux_cal_done;
  logic                aux_cal_ok;
  logic [15:0]         aux_code;
  logic                coef_wr;
  logic [7:0]          rdata_q;

  // mode decode and run enables
  assign mode_idle = (conversion_mode_field == sdc_pkg::MODE_POWER_DOWN);
  assign mode_cal  = conversion_mode_field[2];
  assign mode_full = conversion_mode_field[0];
  assign temp_sel  = ({aux_config_q[sdc_pkg::AUX_CH_HI_BIT], aux_config_q[sdc_pkg::AUX_CH_LO_BIT]}
                      == sdc_pkg::AUX_CH_TEMP);
  assign pri_run   = !mode_idle && pri_enable && state_q != sdc_pkg::SDC_IDLE;
  assign aux_run   = !mode_idle && aux_enable && state_q != sdc_pkg::SDC_IDLE;
  // calibration borrows the slowest rate, programmed value untouched
  assign decim_eff = (state_q == sdc_pkg::SDC_CAL) ? sdc_pkg::DECIMATION_CAL : decimation_q;
  // coefficient writes only land in power-down
  assign coef_wr   = sfr_wr && mode_idle;

  // ---------------------------------------------------------------
  // modulator clock enable
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      div_q <= '0;
    else if (div_q == 13'(MOD_DIV - 1))
      div_q <= '0;
    else
      div_q <= div_q + 13'h0001;
  end

  // tick marks the last clock of each modulator period
  assign mod_tick     = (div_q == 13'(MOD_DIV - 1));
  assign mod_tick_out = mod_tick;

  // one period timer per converter, shared decimation
  sdc_rate_gen u_pri_rate
  (
    .clock       (clock),
    .rst_b       (rst_b),
    .mod_tick    (mod_tick),
    .run         (pri_run),
    .decim       (decim_eff),
    .period_tick (),
    .data_ready  (pri_ready)
  );

  sdc_rate_gen u_aux_rate
  (
    .clock       (clock),
    .rst_b       (rst_b),
    .mod_tick    (mod_tick),
    .run         (aux_run),
    .decim       (decim_eff),
    .period_tick (),
    .data_ready  (aux_ready)
  );

  // ---------------------------------------------------------------
  // mode sequencing
  // ---------------------------------------------------------------
  // calibration ends on the first valid period; temp sensor blocks the aux update
  assign pri_cal_done = (state_q == sdc_pkg::SDC_CAL) && pri_ready;
  assign aux_cal_done = (state_q == sdc_pkg::SDC_CAL) && aux_ready;
  assign aux_cal_ok   = aux_cal_done && !temp_sel;

  // state follows the mode field; calibration ends itself
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= sdc_pkg::SDC_IDLE;
    else
    begin
      unique case (state_q)
        // hold off while mode_clear is pending; the field returns to 000 a cycle later
        sdc_pkg::SDC_IDLE:
          if (!mode_idle && !mode_clear)
            state_q <= mode_cal ? sdc_pkg::SDC_CAL : sdc_pkg::SDC_CONV;
        sdc_pkg::SDC_CONV:
          if (mode_idle)
            state_q <= sdc_pkg::SDC_IDLE;
        sdc_pkg::SDC_CAL:
          if (mode_idle || pri_cal_done || aux_cal_done)
            state_q <= sdc_pkg::SDC_IDLE;
        default:
          state_q <= sdc_pkg::SDC_IDLE;
      endcase
    end
  end

  // completion events and request to return the mode field to 000
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_clear     <= 1'b0;
      pri_done_flag  <= 1'b0;
      aux_done_flag  <= 1'b0;
      aux_fault_flag <= 1'b0;
    end
    else
    begin
      mode_clear     <= pri_cal_done || aux_cal_done;
      pri_done_flag  <= pri_ready;
      aux_done_flag  <= aux_ready;
      aux_fault_flag <= aux_cal_done && temp_sel;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // aux config, reserved bits masked off
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      aux_config_q <= sdc_pkg::AUX_CONFIG_RESET;
    else if (sfr_wr && sfr_addr == sdc_pkg::ADDR_AUX_CONFIG)
      aux_config_q <= sfr_wdata & sdc_pkg::AUX_CONFIG_MASK;  // reserved bits stay zero
  end

  // decimation factor, locked while converting
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      decimation_q <= sdc_pkg::DECIMATION_RESET;
    else if (sfr_wr && sfr_addr == sdc_pkg::ADDR_DECIMATION && !pri_run && !aux_run)
      decimation_q <= sfr_wdata;  // range kept by software
  end

  // analog routing from the config bits
  assign aux_external_ref_select = aux_config_q[sdc_pkg::AUX_EXT_REF_BIT];
  assign aux_channel_sel_hi      = aux_config_q[sdc_pkg::AUX_CH_HI_BIT];
  assign aux_channel_sel_lo      = aux_config_q[sdc_pkg::AUX_CH_LO_BIT];
  assign aux_temp_route          = temp_sel;

  // ---------------------------------------------------------------
  // result coding and result registers
  // ---------------------------------------------------------------
  // aux coding: temp sensor, unipolar clamp or bipolar offset
  always_comb
  begin
    if (temp_sel)
      aux_code = {sdc_pkg::TEMP_ZERO_HIGH + temp_degrees, 8'h00};
    else if (aux_config_q[sdc_pkg::AUX_UNIPOLAR_BIT])
      aux_code = aux_sample[15] ? sdc_pkg::UNIPOLAR_ZERO : aux_sample;
    else
      aux_code = aux_sample ^ sdc_pkg::BIPOLAR_ZERO;
  end

  // results change only from the converter side
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pri_result_q <= {sdc_pkg::RESULT_RESET, sdc_pkg::RESULT_RESET};
      aux_result_q <= {sdc_pkg::RESULT_RESET, sdc_pkg::RESULT_RESET};
    end
    else if (state_q == sdc_pkg::SDC_CONV)
    begin
      if (pri_ready)
        pri_result_q <= pri_sample ^ sdc_pkg::BIPOLAR_ZERO;
      if (aux_ready)
        aux_result_q <= aux_code;
    end
  end

  // ---------------------------------------------------------------
  // calibration coefficients
  // ---------------------------------------------------------------
  // primary offset, calibration wins over a software write
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      pri_offset_q <= sdc_pkg::OFFSET_RESET;
    else if (pri_cal_done && !mode_full)
      pri_offset_q <= pri_cal_word;
    else if (coef_wr && sfr_addr == sdc_pkg::ADDR_PRI_OFFSET_MID)
      pri_offset_q[7:0] <= sfr_wdata;
    else if (coef_wr && sfr_addr == sdc_pkg::ADDR_PRI_OFFSET_HIGH)
      pri_offset_q[15:8] <= sfr_wdata;
  end

  // aux offset, left alone by a failed temp sensor calibration
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      aux_offset_q <= sdc_pkg::OFFSET_RESET;
    else if (aux_cal_ok && !mode_full)
      aux_offset_q <= aux_cal_word;
    else if (coef_wr && sfr_addr == sdc_pkg::ADDR_AUX_OFFSET_LOW)
      aux_offset_q[7:0] <= sfr_wdata;
    else if (coef_wr && sfr_addr == sdc_pkg::ADDR_AUX_OFFSET_HIGH)
      aux_offset_q[15:8] <= sfr_wdata;
  end

  // primary gain, full-scale calibration only
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      pri_gain_q <= PRI_GAIN_RESET;
    else if (pri_cal_done && mode_full)
      pri_gain_q <= pri_cal_word;
    else if (coef_wr && sfr_addr == sdc_pkg::ADDR_PRI_GAIN_MID)
      pri_gain_q[7:0] <= sfr_wdata;
    else if (coef_wr && sfr_addr == sdc_pkg::ADDR_PRI_GAIN_HIGH)
      pri_gain_q[15:8] <= sfr_wdata;
  end

  // aux gain, full-scale calibration only
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      aux_gain_q <= AUX_GAIN_RESET;
    else if (aux_cal_ok && mode_full)
      aux_gain_q <= aux_cal_word;
    else if (coef_wr && sfr_addr == sdc_pkg::ADDR_AUX_GAIN_LOW)
      aux_gain_q[7:0] <= sfr_wdata;
    else if (coef_wr && sfr_addr == sdc_pkg::ADDR_AUX_GAIN_HIGH)
      aux_gain_q[15:8] <= sfr_wdata;
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // read mux, unmapped addresses read as zero
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      rdata_q <= sdc_pkg::READ_UNMAPPED;
    else if (sfr_rd)
    begin
      unique case (sfr_addr)
        sdc_pkg::ADDR_AUX_CONFIG:      rdata_q <= aux_config_q;
        sdc_pkg::ADDR_DECIMATION:      rdata_q <= decimation_q;
        sdc_pkg::ADDR_PRI_RESULT_MID:  rdata_q <= pri_result_q[7:0];
        sdc_pkg::ADDR_PRI_RESULT_HIGH: rdata_q <= pri_result_q[15:8];
        sdc_pkg::ADDR_AUX_RESULT_LOW:  rdata_q <= aux_result_q[7:0];
        sdc_pkg::ADDR_AUX_RESULT_HIGH: rdata_q <= aux_result_q[15:8];
        sdc_pkg::ADDR_PRI_OFFSET_MID:  rdata_q <= pri_offset_q[7:0];
        sdc_pkg::ADDR_PRI_OFFSET_HIGH: rdata_q <= pri_offset_q[15:8];
        sdc_pkg::ADDR_AUX_OFFSET_LOW:  rdata_q <= aux_offset_q[7:0];
        sdc_pkg::ADDR_AUX_OFFSET_HIGH: rdata_q <= aux_offset_q[15:8];
        sdc_pkg::ADDR_PRI_GAIN_MID:    rdata_q <= pri_gain_q[7:0];
        sdc_pkg::ADDR_PRI_GAIN_HIGH:   rdata_q <= pri_gain_q[15:8];
        sdc_pkg::ADDR_AUX_GAIN_LOW:    rdata_q <= aux_gain_q[7:0];
        sdc_pkg::ADDR_AUX_GAIN_HIGH:   rdata_q <= aux_gain_q[15:8];
        default:                       rdata_q <= sdc_pkg::READ_UNMAPPED;
      endcase
    end
  end

  // registered read data straight to the port
  assign sfr_rdata = rdata_q;

endmodule // sdc_conv_ctrl

// file: sdc_chk.sv
`timescale 1ns/1ps
module sdc_chk
#(
  parameter int MOD_DIV = 4
)
(
  // clock and reset
  input wire logic       clock,
  input wire logic       rst_b,
  // register port
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // mode and events
  input wire logic [2:0] conversion_mode_field,
  input wire logic       mode_clear,
  input wire logic       mod_tick_out,
  input wire logic       aux_done_flag,
  input wire logic       aux_fault_flag,
  // routing
  input wire logic       aux_external_ref_select,
  input wire logic       aux_channel_sel_hi,
  input wire logic       aux_channel_sel_lo,
  input wire logic       aux_temp_route
);
  // ----
  // helpers
  // ----
  int   gap_q;
  int   ticks_q;
  logic seen_q;
  logic done_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // clocks since the last modulator tick
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      gap_q  <= 0;
      seen_q <= 1'b0;
    end
    else if (mod_tick_out)
    begin
      gap_q  <= 1;
      seen_q <= 1'b1;
    end
    else
      gap_q <= gap_q + 1;

  // modulator ticks and first result since a conversion start
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      ticks_q <= 0;
      done_q  <= 1'b0;
    end
    else if (conversion_mode_field == 3'h0)
    begin
      ticks_q <= 0;
      done_q  <= 1'b0;
    end
    else
    begin
      ticks_q <= ticks_q + (mod_tick_out ? 1 : 0);
      done_q  <= done_q | aux_done_flag;
    end

  // ----
  // assertions
  // ----
  AST_EXT_REF: assert property (sfr_wr && sfr_addr == sdc_pkg::ADDR_AUX_CONFIG |=>
    aux_external_ref_select == $past(sfr_wdata[6])) else $error("reference select mismatch");
  AST_CHANNEL: assert property (sfr_wr && sfr_addr == sdc_pkg::ADDR_AUX_CONFIG |=>
    {aux_channel_sel_hi, aux_channel_sel_lo} == $past(sfr_wdata[5:4])) else $error("channel mismatch");
  AST_TEMP_ROUTE: assert property (aux_temp_route == (aux_channel_sel_hi && !aux_channel_sel_lo))
    else $error("temp route mismatch");
  AST_CONFIG_READ: assert property (sfr_rd && !sfr_wr && sfr_addr == sdc_pkg::ADDR_AUX_CONFIG |=>
    sfr_rdata[6:4] == {aux_external_ref_select, aux_channel_sel_hi, aux_channel_sel_lo})
    else $error("config readback mismatch");
  AST_TICK_GAP: assert property (mod_tick_out && seen_q |-> gap_q == MOD_DIV)
    else $error("tick spacing wrong");
  AST_SETTLE: assert property (aux_done_flag && !done_q && conversion_mode_field != 3'h0
    && !conversion_mode_field[2] |-> ticks_q >= 624) else $error("first result too early");
  AST_CLEAR_CAL: assert property (mode_clear |-> conversion_mode_field[2])
    else $error("mode clear outside calibration");
  AST_CLEAR_PULSE: assert property (mode_clear |=> !mode_clear)
    else $error("mode clear too long");
  AST_FAULT: assert property (aux_fault_flag |-> aux_done_flag && aux_temp_route)
    else $error("fault without done");
endmodule // sdc_chk

bind sdc_conv_ctrl sdc_chk #(.MOD_DIV(MOD_DIV)) u_chk (.clock(clock), .rst_b(rst_b),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata), .conversion_mode_field(conversion_mode_field),
  .mode_clear(mode_clear), .mod_tick_out(mod_tick_out), .aux_done_flag(aux_done_flag),
  .aux_fault_flag(aux_fault_flag), .aux_external_ref_select(aux_external_ref_select),
  .aux_channel_sel_hi(aux_channel_sel_hi), .aux_channel_sel_lo(aux_channel_sel_lo),
  .aux_temp_route(aux_temp_route));

// file: sdc_mode_reg.sv
`timescale 1ns/1ps
module sdc_mode_reg
(
  // clock and reset
  input wire logic       clock,
  input wire logic       rst_b,
  // core side write
  input wire logic       mode_wr,
  input wire logic [2:0] mode_wdata,
  // converter side
  input wire logic       mode_clear,
  output logic [2:0]     conversion_mode_field
);
  // mode register held by the core
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      conversion_mode_field <= 3'h0;
    else if (mode_clear)
      conversion_mode_field <= 3'h0;  // back to power-down
    else if (mode_wr)
      conversion_mode_field <= mode_wdata;
endmodule // sdc_mode_reg

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  // ----
  // signals
  // ----
  localparam logic [15:0] GAIN = 16'h5000;  // arbitrary factory value
  logic        clock, rst_b, sfr_wr, sfr_rd, pri_enable, aux_enable, mode_wr, mode_clear;
  logic        mod_tick_out, pri_done_flag, aux_done_flag, aux_fault_flag, rd_pend, fault_seen;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, temp_degrees, data, aux_off;
  logic [15:0] pri_sample, aux_sample, pri_cal_word, aux_cal_word;
  logic [2:0]  conversion_mode_field, mode_wdata;
  logic [7:0]  exp_q[$];
  logic [7:0]  ra[14] = '{8'hD3, 8'hD4, 8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hE2, 8'hE3, 8'hE4, 8'hE5,
                         8'hEA, 8'hEB, 8'hEC, 8'hED};
  logic [7:0]  rv[14] = '{8'h00, 8'h45, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h80,
                         GAIN[7:0], GAIN[15:8], GAIN[7:0], GAIN[15:8]};
  int          n_errors, cmp_count, seed;

  // ----
  // design and partner
  // ----
  sdc_conv_ctrl #(.MOD_DIV(2), .PRI_GAIN_RESET(GAIN), .AUX_GAIN_RESET(GAIN)) DUT (.clock(clock),
    .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .conversion_mode_field(conversion_mode_field), .pri_enable(pri_enable),
    .aux_enable(aux_enable), .mode_clear(mode_clear), .pri_sample(pri_sample), .aux_sample(aux_sample),
    .temp_degrees(temp_degrees), .pri_cal_word(pri_cal_word), .aux_cal_word(aux_cal_word),
    .aux_external_ref_select(), .aux_channel_sel_hi(), .aux_channel_sel_lo(), .aux_temp_route(),
    .mod_tick_out(mod_tick_out), .pri_done_flag(pri_done_flag), .aux_done_flag(aux_done_flag),
    .aux_fault_flag(aux_fault_flag));
  sdc_mode_reg u_mode (.clock(clock), .rst_b(rst_b), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
    .mode_clear(mode_clear), .conversion_mode_field(conversion_mode_field));

  // clock generator
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ----
  // tasks
  // ----
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
    @(negedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    exp_q.push_back(e);
    @(negedge clock);
    sfr_rd = 1'b0;
    @(negedge clock);
  endtask

  task automatic set_mode(input logic [2:0] m);
    mode_wdata = m;
    mode_wr = 1'b1;
    @(negedge clock);
    mode_wr = 1'b0;
    @(negedge clock);
  endtask

  task automatic wait_pulse(input bit on_clear, input int lim);
    int i;
    for (i = 0; i < lim && (on_clear ? mode_clear : aux_done_flag) !== 1'b1; i++)
      @(negedge clock);
    if (i == lim)
    begin
      n_errors++;
      $display("ERROR wait_pulse expected 1 seen 0");
      results();
    end
  endtask

  task automatic convert(input logic [7:0] cfg, input logic [15:0] ea, input logic [15:0] ep);
    wr(8'hD3, cfg);
    set_mode(3'h1);
    wr(8'hD4, 8'hFF);
    wr(8'hE4, ~aux_off);
    wait_pulse(1'b0, 4000);
    check("pri_done_flag", 8'h01, {7'h00, pri_done_flag});
    rd(8'hDD, ea[15:8]);
    rd(8'hDC, ea[7:0]);
    rd(8'hDB, ep[15:8]);
    rd(8'hDA, ep[7:0]);
    rd(8'hD4, 8'h0D);
    rd(8'hE4, aux_off);
    set_mode(3'h0);
  endtask

  // ----
  // read watcher: compares each read with the oldest note
  // ----
  always @(posedge clock)
    rd_pend <= sfr_rd;
  always @(negedge clock)
    if (rd_pend === 1'b1)
      check("sfr_rdata", exp_q.pop_front(), sfr_rdata);
  always @(negedge clock)
    if (aux_fault_flag === 1'b1)
      fault_seen = 1'b1;

  // ----
  // main sequence
  // ----
  initial
  begin
    seed = 14;
    {rst_b, sfr_wr, sfr_rd, mode_wr, pri_enable, aux_enable, fault_seen} = '0;
    {sfr_addr, sfr_wdata, temp_degrees, mode_wdata, aux_off} = '0;
    {pri_sample, aux_sample, pri_cal_word, aux_cal_word} = '0;
    {n_errors, cmp_count} = '0;
    repeat (16) @(negedge clock);
    rst_b = 1'b1;
    @(negedge clock);
    foreach (ra[i]) rd(ra[i], rv[i]);
    rd(8'h00, 8'h00);
    // every channel code, temp sensor with internal reference and bipolar coding
    for (int c = 0; c < 4; c++)
    begin
      data = 8'($random(seed));
      data[5:4] = 2'(c);
      if (c == 2)
        data = data & 8'hB7;
      wr(8'hD3, data);
      rd(8'hD3, data & 8'h78);
    end
    // idle coefficient write lands, result write is dropped
    aux_off = 8'($random(seed));
    wr(8'hE4, aux_off);
    rd(8'hE4, aux_off);
    wr(8'hDD, 8'h5A);
    rd(8'hDD, 8'h00);
    wr(8'hD4, 8'h0D);
    rd(8'hD4, 8'h0D);
    // unipolar zero and bipolar primary, then the temp sensor
    {pri_enable, aux_enable} = 2'b11;
    pri_sample = 16'($random(seed));
    convert(8'h58, 16'h0000, pri_sample ^ 16'h8000);
    convert(8'h10, 16'h8000, pri_sample ^ 16'h8000);
    temp_degrees = 8'($random(seed)) & 8'h1F;
    convert(8'h20, {8'h80 + temp_degrees, 8'h00}, pri_sample ^ 16'h8000);
    // zero-scale calibration with the temp sensor still routed
    pri_cal_word = 16'($random(seed));
    aux_cal_word = ~pri_cal_word;
    set_mode(3'h4);
    wait_pulse(1'b1, 60000);
    @(negedge clock);
    check("conversion_mode_field", 8'h00, {5'h00, conversion_mode_field});
    check("aux_fault_flag", 8'h01, {7'h00, fault_seen});
    rd(8'hE2, pri_cal_word[7:0]);
    rd(8'hE3, pri_cal_word[15:8]);
    rd(8'hE4, aux_off);
    rd(8'hD4, 8'h0D);
    // full-scale then zero-scale calibration on input four
    wr(8'hD3, 8'h10);
    set_mode(3'h5);
    wait_pulse(1'b1, 60000);
    rd(8'hEA, pri_cal_word[7:0]);
    rd(8'hEB, pri_cal_word[15:8]);
    rd(8'hEC, aux_cal_word[7:0]);
    rd(8'hED, aux_cal_word[15:8]);
    rd(8'hE3, pri_cal_word[15:8]);
    set_mode(3'h4);
    wait_pulse(1'b1, 60000);
    rd(8'hE4, aux_cal_word[7:0]);
    rd(8'hE5, aux_cal_word[15:8]);
    repeat (2) @(negedge clock);
    results();
  end
endmodule // testbench
